// ==== src/pcrc_pkg.sv ====
// Purpose: Constants and types shared by the programmable CRC block
// Assumes: 32-bit classic Wishbone slave, byte addresses
// Notes: Control registers are 16 bits wide in the low half of a word
package pcrc_pkg;
	// ****************************************************************
	// Register byte addresses
	// ****************************************************************
	localparam logic [7:0] CTRL_LO_ADR = 8'h00;
	localparam logic [7:0] CTRL_HI_ADR = 8'h04;
	localparam logic [7:0] POLY_LO_ADR = 8'h08;
	localparam logic [7:0] POLY_HI_ADR = 8'h0c;
	localparam logic [7:0] DATA_ADR = 8'h10;
	localparam logic [7:0] RESULT_ADR = 8'h14;
	localparam logic [7:0] IRQ_STAT_ADR = 8'h18;
	localparam logic [7:0] IRQ_MASK_ADR = 8'h1c;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int ON_BIT = 15;
	localparam int IDLE_STOP_BIT = 13;
	localparam int COUNT_LSB = 8;
	localparam int FULL_BIT = 7;
	localparam int EMPTY_BIT = 6;
	localparam int ISEL_BIT = 5;
	localparam int GO_BIT = 4;
	localparam int LSB_FIRST_BIT = 3;
	localparam int VARIANT_BIT = 2;
	localparam int WIDTH_LSB = 8;
	localparam int POLY_LENGTH_MINUS_ONE_LSB = 0;

	// ****************************************************************
	// Sizes and limits
	// ****************************************************************
	localparam int FIFO_DEPTH = 16;
	localparam logic [4:0] FIFO_MAX_SHORT = 5'h10;
	localparam logic [4:0] FIFO_MAX_LONG = 5'h08;
	localparam logic [4:0] POLY_LENGTH_MINUS_ONE_LONG_MIN = 5'h07;
	localparam logic [15:0] POLY_LO_MASK = 16'hfffe;
	localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
	localparam logic [4:0] TOP_BIT = 5'h1f;

	typedef enum logic {PCRC_IDLE, PCRC_SHIFT} pcrc_phase_e;

	// Whole state of the block
	typedef struct packed {
		logic on;
		logic idle_stop;
		logic isel;
		logic go;
		logic lsb_first;
		logic variant;
		logic [4:0] width_m1;
		logic [4:0] poly_length_minus_one_m1;
		logic [15:0] poly_lo;
		logic [15:0] poly_hi;
		logic [31:0] crc;
		logic [31:0] sr;
		logic [4:0] bits_left;
		pcrc_phase_e phase;
		logic [3:0] rd_ptr;
		logic [3:0] wr_ptr;
		logic [4:0] count;
		logic ist;
		logic imask;
		logic irq;
		logic ack;
		logic [31:0] dat;
		logic [FIFO_DEPTH-1:0][31:0] fifo;
	} pcrc_state_s;
endpackage

// ==== src/pcrc_top.sv ====
// Purpose: Programmable CRC generator with data FIFO, Wishbone slave
// Assumes: Single 50 MHz clock, synchronous active-low reset
// Notes: Serial engine consumes one data bit per clock
//
// Overview of operation
// - The on bit enables the whole block and resets to zero.
// - With idle-stop set the engine freezes while the device idles.
// - A read-only count shows FIFO words; pushes stop at 8 or 16 by length.
// - The full flag is set while the count is at or above its 8 or 16 limit.
// - The empty flag is set while the FIFO is empty, one at reset.
// - With event select set, the interrupt fires when the FIFO empties.
// - With event select clear, it fires when shifting has completed.
// - Software sets start to run the shifter; hardware may clear it.
// - Direction bit set shifts each word LSB first, else MSB first.
// - The variant bit picks alternate or legacy calculation mode.
// - The width field holds data word width minus one.
// - The length field holds polynomial length minus one.
// - Unimplemented bits read zero and ignore writes.
`timescale 1ns/1ns
module pcrc_top (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic idle_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	output logic irq_out
);
	// ****************************************************************
	// Helper functions
	// ****************************************************************
	// Mask of crc bits in use
	function automatic logic [31:0] len_mask(input logic [4:0] poly_length_minus_one);
		len_mask = pcrc_pkg::ALL_ONES >> (pcrc_pkg::TOP_BIT - poly_length_minus_one);
	endfunction

	// FIFO limit for a polynomial length
	function automatic logic [4:0] fifo_max(input logic [4:0] poly_length_minus_one);
		fifo_max = (poly_length_minus_one >= pcrc_pkg::POLY_LENGTH_MINUS_ONE_LONG_MIN) ?
			pcrc_pkg::FIFO_MAX_LONG : pcrc_pkg::FIFO_MAX_SHORT;
	endfunction

	// Byte-lane write mask
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// ****************************************************************
	// State and next state
	// ****************************************************************
	pcrc_pkg::pcrc_state_s st_ff;
	pcrc_pkg::pcrc_state_s nxt_st;
	logic req;
	logic wr;
	logic [31:0] wm;
	logic [31:0] wd;
	logic run;
	logic push;
	logic pop;
	logic din;
	logic fb;
	logic [31:0] poly;
	logic [31:0] cmask;
	logic [31:0] c;
	logic [15:0] ctrl_lo;
	logic [15:0] ctrl_hi;

	// Request decode and derived control
	always_comb begin
		req = wb_cyc_in && wb_stb_in && !st_ff.ack;
		wr = req && wb_we_in;
		wm = lane_mask(wb_sel_in);
		run = st_ff.on && !(st_ff.idle_stop && idle_in);
		poly = {st_ff.poly_hi, st_ff.poly_lo} | 32'h0000_0001;
		cmask = len_mask(st_ff.poly_length_minus_one_m1);
		ctrl_lo = '0;
		ctrl_lo[pcrc_pkg::ON_BIT] = st_ff.on;
		ctrl_lo[pcrc_pkg::IDLE_STOP_BIT] = st_ff.idle_stop;
		ctrl_lo[pcrc_pkg::COUNT_LSB +: 5] = st_ff.count;
		// Full also covers a count left above a lowered limit
		ctrl_lo[pcrc_pkg::FULL_BIT] =
			(st_ff.count >= fifo_max(st_ff.poly_length_minus_one_m1));
		ctrl_lo[pcrc_pkg::EMPTY_BIT] = (st_ff.count == 5'h00);
		ctrl_lo[pcrc_pkg::ISEL_BIT] = st_ff.isel;
		ctrl_lo[pcrc_pkg::GO_BIT] = st_ff.go;
		ctrl_lo[pcrc_pkg::LSB_FIRST_BIT] = st_ff.lsb_first;
		ctrl_lo[pcrc_pkg::VARIANT_BIT] = st_ff.variant;
		ctrl_hi = '0;
		ctrl_hi[pcrc_pkg::WIDTH_LSB +: 5] = st_ff.width_m1;
		ctrl_hi[pcrc_pkg::POLY_LENGTH_MINUS_ONE_LSB +: 5] = st_ff.poly_length_minus_one_m1;
	end

	// ****************************************************************
	// Next-state logic: bus slave, FIFO, engine, interrupt
	// ****************************************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = req;
		nxt_st.dat = '0;
		wd = wb_dat_in & wm;
		push = 1'b0;
		pop = 1'b0;
		din = 1'b0;
		fb = 1'b0;
		c = st_ff.crc;
		// Register reads, unmapped reads return zero
		if (req && !wb_we_in) begin
			case (wb_adr_in)
				pcrc_pkg::CTRL_LO_ADR: nxt_st.dat = {16'h0000, ctrl_lo};
				pcrc_pkg::CTRL_HI_ADR: nxt_st.dat = {16'h0000, ctrl_hi};
				pcrc_pkg::POLY_LO_ADR: nxt_st.dat = {16'h0000, st_ff.poly_lo};
				pcrc_pkg::POLY_HI_ADR: nxt_st.dat = {16'h0000, st_ff.poly_hi};
				pcrc_pkg::RESULT_ADR: nxt_st.dat = st_ff.crc;
				pcrc_pkg::IRQ_STAT_ADR: nxt_st.dat = {31'h0, st_ff.ist};
				pcrc_pkg::IRQ_MASK_ADR: nxt_st.dat = {31'h0, st_ff.imask};
				default: nxt_st.dat = '0;
			endcase
		end
		// Register writes; reserved bits are dropped
		if (wr && wb_sel_in[1]) begin
			case (wb_adr_in)
				pcrc_pkg::CTRL_LO_ADR: begin
					nxt_st.on = wb_dat_in[pcrc_pkg::ON_BIT];
					nxt_st.idle_stop = wb_dat_in[pcrc_pkg::IDLE_STOP_BIT];
				end
				pcrc_pkg::CTRL_HI_ADR: begin
					nxt_st.width_m1 = wb_dat_in[pcrc_pkg::WIDTH_LSB +: 5];
				end
				pcrc_pkg::POLY_LO_ADR: nxt_st.poly_lo[15:8] = wb_dat_in[15:8];
				pcrc_pkg::POLY_HI_ADR: nxt_st.poly_hi[15:8] = wb_dat_in[15:8];
				default: ;
			endcase
		end
		if (wr && wb_sel_in[0]) begin
			case (wb_adr_in)
				pcrc_pkg::CTRL_LO_ADR: begin
					nxt_st.isel = wb_dat_in[pcrc_pkg::ISEL_BIT];
					nxt_st.go = wb_dat_in[pcrc_pkg::GO_BIT];
					nxt_st.lsb_first = wb_dat_in[pcrc_pkg::LSB_FIRST_BIT];
					nxt_st.variant = wb_dat_in[pcrc_pkg::VARIANT_BIT];
				end
				pcrc_pkg::CTRL_HI_ADR: begin
					nxt_st.poly_length_minus_one_m1 = wb_dat_in[pcrc_pkg::POLY_LENGTH_MINUS_ONE_LSB +: 5];
				end
				pcrc_pkg::POLY_LO_ADR: begin
					nxt_st.poly_lo[7:0] = wb_dat_in[7:0] &
						pcrc_pkg::POLY_LO_MASK[7:0];
				end
				pcrc_pkg::POLY_HI_ADR: nxt_st.poly_hi[7:0] = wb_dat_in[7:0];
				pcrc_pkg::IRQ_STAT_ADR: nxt_st.ist = st_ff.ist & !wb_dat_in[0];
				pcrc_pkg::IRQ_MASK_ADR: nxt_st.imask = wb_dat_in[0];
				default: ;
			endcase
		end
		if (wr && wb_adr_in == pcrc_pkg::RESULT_ADR) begin
			nxt_st.crc = (st_ff.crc & ~wm) | wd; // Seed preset
		end
		// Word push; ignored while off or full
		// Count may sit above a lowered limit until drained
		if (wr && wb_adr_in == pcrc_pkg::DATA_ADR && st_ff.on &&
			st_ff.count < fifo_max(st_ff.poly_length_minus_one_m1)) begin
			push = 1'b1;
			nxt_st.fifo[st_ff.wr_ptr] = wd;
			nxt_st.wr_ptr = st_ff.wr_ptr + 4'h1;
		end
		// Serial engine, one bit per clock while running
		if (run) begin
			case (st_ff.phase)
				pcrc_pkg::PCRC_IDLE: begin
					if (st_ff.go && st_ff.count != 5'h00) begin
						pop = 1'b1;
					end
				end
				pcrc_pkg::PCRC_SHIFT: begin
					din = st_ff.lsb_first ? st_ff.sr[0] : st_ff.sr[31];
					nxt_st.sr = st_ff.lsb_first ? (st_ff.sr >> 1) :
						(st_ff.sr << 1);
					if (st_ff.variant) begin
						fb = st_ff.crc[st_ff.poly_length_minus_one_m1] ^ din;
						c = (st_ff.crc << 1) & cmask;
					end else begin
						fb = st_ff.crc[st_ff.poly_length_minus_one_m1];
						c = ((st_ff.crc << 1) | {31'h0, din}) & cmask;
					end
					nxt_st.crc = fb ? ((c ^ poly) & cmask) : c;
					nxt_st.bits_left = st_ff.bits_left - 5'h01;
					if (!st_ff.go) begin
						nxt_st.phase = pcrc_pkg::PCRC_IDLE;
					end else if (st_ff.bits_left == 5'h00) begin
						if (st_ff.count != 5'h00) begin
							pop = 1'b1;
						end else begin
							nxt_st.phase = pcrc_pkg::PCRC_IDLE;
							nxt_st.go = 1'b0;
							if (!st_ff.isel) begin
								nxt_st.ist = 1'b1;
							end
						end
					end
				end
				default: nxt_st.phase = pcrc_pkg::PCRC_IDLE;
			endcase
		end
		// Pop loads the shifter, aligned for the chosen direction
		if (pop) begin
			nxt_st.phase = pcrc_pkg::PCRC_SHIFT;
			nxt_st.bits_left = st_ff.width_m1;
			nxt_st.sr = st_ff.lsb_first ? st_ff.fifo[st_ff.rd_ptr] :
				(st_ff.fifo[st_ff.rd_ptr] <<
				(pcrc_pkg::TOP_BIT - st_ff.width_m1));
			nxt_st.rd_ptr = st_ff.rd_ptr + 4'h1;
			if (st_ff.isel && st_ff.count == 5'h01 && !push) begin
				nxt_st.ist = 1'b1;
			end
		end
		nxt_st.count = st_ff.count + {4'h0, push} - {4'h0, pop};
		// Turning the block off flushes FIFO and engine
		if (!st_ff.on) begin
			nxt_st.phase = pcrc_pkg::PCRC_IDLE;
			nxt_st.count = 5'h00;
			nxt_st.rd_ptr = 4'h0;
			nxt_st.wr_ptr = 4'h0;
		end
		nxt_st.irq = nxt_st.ist && nxt_st.imask;
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign wb_dat_out = st_ff.dat;
	assign wb_ack_out = st_ff.ack;
	assign irq_out = st_ff.irq;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence last_pop_s;
		pop && st_ff.isel && st_ff.count == 5'h01 && !push;
	endsequence
	sequence word_done_s;
		run && st_ff.phase == pcrc_pkg::PCRC_SHIFT && st_ff.go &&
			st_ff.bits_left == 5'h00 && st_ff.count == 5'h00;
	endsequence

	// Enable, idle stop and FIFO status
	module_off_a: assert property (!st_ff.on |=>
		st_ff.count == 5'h00 && st_ff.phase == pcrc_pkg::PCRC_IDLE)
		else $error("block off but FIFO or engine active");
	idle_freeze_a: assert property (st_ff.on && st_ff.idle_stop &&
		idle_in && !(wr && wb_adr_in == pcrc_pkg::RESULT_ADR) |=>
		$stable(st_ff.crc) && $stable(st_ff.rd_ptr))
		else $error("engine moved while stopped in idle");
	count_limit_a: assert property (
		st_ff.count <= pcrc_pkg::FIFO_MAX_SHORT &&
		(!push || st_ff.count < fifo_max(st_ff.poly_length_minus_one_m1)))
		else $error("FIFO count above its limit");
	full_flag_a: assert property (push && !pop &&
		st_ff.count == fifo_max(st_ff.poly_length_minus_one_m1) - 5'h01 |=>
		ctrl_lo[pcrc_pkg::FULL_BIT] && st_ff.count != 5'h00)
		else $error("full flag clear after filling the FIFO");

	// Interrupt events and start bit
	empty_flag_a: assert property (last_pop_s |=>
		ctrl_lo[pcrc_pkg::EMPTY_BIT])
		else $error("empty flag clear after last pop");
	empty_irq_a: assert property (last_pop_s |=> st_ff.ist)
		else $error("no event when FIFO emptied");
	done_irq_a: assert property (word_done_s and !st_ff.isel |=>
		st_ff.ist ##0 st_ff.phase == pcrc_pkg::PCRC_IDLE)
		else $error("no event after shifting completed");
	start_clear_a: assert property (word_done_s |=>
		!st_ff.go || $past(wr))
		else $error("start bit not cleared at completion");
	poly_bit0_a: assert property (st_ff.poly_lo[0] == 1'b0)
		else $error("polynomial bit 0 set");
	ack_pulse_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
		|=> wb_ack_out ##1 !wb_ack_out)
		else $error("bus ack not a single cycle");
	irq_level_a: assert property (st_ff.ist && st_ff.imask |=> irq_out
		|| $past(wr))
		else $error("interrupt not raised for unmasked event");

	// Bus answer: data only with ack, ack only on request
	dat_quiet_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
		else $error("read data shown without ack");
	ack_idle_a: assert property (!(wb_cyc_in && wb_stb_in) |=>
		!wb_ack_out)
		else $error("ack without a request");

	// Engine steps: shift, load, pop, start, abort, hold
	sequence shift_s;
		run && st_ff.phase == pcrc_pkg::PCRC_SHIFT && !pop;
	endsequence

	lsb_shift_a: assert property (shift_s and st_ff.lsb_first |=>
		st_ff.sr == ($past(st_ff.sr) >> 1))
		else $error("shifter not moving toward bit 0");
	msb_shift_a: assert property (shift_s and !st_ff.lsb_first |=>
		st_ff.sr == ($past(st_ff.sr) << 1))
		else $error("shifter not moving toward bit 31");
	word_load_a: assert property (pop |=> st_ff.phase ==
		pcrc_pkg::PCRC_SHIFT && st_ff.bits_left == $past(st_ff.width_m1))
		else $error("word not loaded with its width");
	pop_step_a: assert property (pop |=>
		st_ff.rd_ptr == $past(st_ff.rd_ptr) + 4'h1)
		else $error("read pointer not advanced on pop");
	go_idle_a: assert property (st_ff.phase == pcrc_pkg::PCRC_IDLE &&
		!st_ff.go |=> st_ff.phase == pcrc_pkg::PCRC_IDLE)
		else $error("engine started without start bit");
	stop_abort_a: assert property (run && !st_ff.go &&
		st_ff.phase == pcrc_pkg::PCRC_SHIFT |=>
		st_ff.phase == pcrc_pkg::PCRC_IDLE)
		else $error("engine kept shifting after start cleared");
	crc_hold_a: assert property (st_ff.phase == pcrc_pkg::PCRC_IDLE &&
		!(wr && wb_adr_in == pcrc_pkg::RESULT_ADR) |=> $stable(st_ff.crc))
		else $error("result moved while the engine idled");
	idle_run_a: assert property (st_ff.on && !st_ff.idle_stop &&
		idle_in && st_ff.go && st_ff.phase == pcrc_pkg::PCRC_SHIFT |=>
		$past(st_ff.bits_left) == 5'h00 ||
		st_ff.bits_left == $past(st_ff.bits_left) - 5'h01)
		else $error("engine stalled in idle without idle-stop");
endmodule // pcrc_top

// ==== testbench/pcrc_host.sv ====
// Purpose: Processor-side Wishbone master feeding the CRC block
// Assumes: Classic single cycles, one request at a time
// Notes: A hung slave ends the run through the bench
`timescale 1ns/1ns
module pcrc_host (
	input wire logic clk_in,
	input wire logic ack_in,
	input wire logic [31:0] dat_in,
	output logic cyc_out,
	output logic stb_out,
	output logic we_out,
	output logic [7:0] adr_out,
	output logic [3:0] sel_out,
	output logic [31:0] dat_out
);
	// Idle bus at time zero
	initial begin
		{cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} = '0;
	end

	// One cycle; held until ack is sampled
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_in);
		cyc_out <= 1'b1;
		stb_out <= 1'b1;
		we_out <= w;
		adr_out <= a;
		sel_out <= 4'hf;
		dat_out <= d;
		do begin
			@(posedge clk_in);
			n++;
		end while (ack_in !== 1'b1 && n < 50);
		if (ack_in !== 1'b1) begin
			pcrc_top_bench.hang();
		end
		q = dat_in;
		cyc_out <= 1'b0;
		stb_out <= 1'b0;
		we_out <= 1'b0;
	endtask
endmodule // pcrc_host

// ==== testbench/pcrc_top_bench.sv ====
// Purpose: Self-checking bench for the programmable CRC block
// Assumes: 50 MHz clock, reset held for 20 cycles
// Notes: Result compared on the low polynomial-length bits only
`timescale 1ns/1ns
module pcrc_top_bench;
	logic sys_clk_in, rst_n_in, idle_in, cyc, stb, we, ack, irq;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	int err_count, checked;

	pcrc_top pcrc_top_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(sel), .wb_dat_in(wdat), .idle_in(idle_in),
		.wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq));
	pcrc_host pcrc_host_inst (.clk_in(sys_clk_in), .ack_in(ack),
		.dat_in(rdat), .cyc_out(cyc), .stb_out(stb), .we_out(we),
		.adr_out(adr), .sel_out(sel), .dat_out(wdat));

	// Clock
	initial begin
		sys_clk_in = 1'b0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end

	// Verdict and end of run
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic hang;
		err_count++;
		report_and_stop();
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		pcrc_host_inst.xfer(1'b1, a, d, x);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		pcrc_host_inst.xfer(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	// Poll a register until the masked value appears
	task automatic poll(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] v);
		int n;
		n = 0;
		do begin
			pcrc_host_inst.xfer(1'b0, a, 32'h0, q);
			n++;
		end while ((q & m) !== v && n < 40);
		if ((q & m) !== v) begin
			hang();
		end
	endtask
	// Reference engine, one bit per step
	function automatic logic [31:0] ref_crc(input logic [31:0] c,
		input logic [31:0] d, input int w, input int pl, input logic lsb,
		input logic alt, input logic [31:0] p);
		logic fb, b;
		logic [31:0] m;
		m = (32'h2 << pl) - 32'h1;
		for (int i = 0; i < w; i++) begin
			b = lsb ? d[i] : d[w-1-i];
			fb = alt ? c[pl] ^ b : c[pl];
			c = alt ? (c << 1) & m : ((c << 1) | {31'h0, b}) & m;
			if (fb) begin
				c = c ^ ((p | 32'h1) & m);
			end
		end
		return c;
	endfunction

	task automatic t_regs;
		rchk(pcrc_pkg::CTRL_LO_ADR, 32'h0040);
		rchk(pcrc_pkg::CTRL_HI_ADR, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(pcrc_pkg::CTRL_HI_ADR, 32'hffff);
		rchk(pcrc_pkg::CTRL_HI_ADR, 32'h1f1f);
		wr(pcrc_pkg::POLY_LO_ADR, 32'hffff);
		rchk(pcrc_pkg::POLY_LO_ADR, 32'hfffe);
		wr(pcrc_pkg::POLY_HI_ADR, 32'hffff);
		rchk(pcrc_pkg::POLY_HI_ADR, 32'hffff);
		wr(pcrc_pkg::CTRL_LO_ADR, 32'h600f);
		rchk(pcrc_pkg::CTRL_LO_ADR, 32'h204c);
		wr(8'h20, 32'h1234);
		rchk(8'h20, 32'h0);
		wr(pcrc_pkg::POLY_HI_ADR, 32'h0);
		wr(pcrc_pkg::CTRL_LO_ADR, 32'h0);
		$display("test regs done");
	endtask

	task automatic t_fill;
		wr(pcrc_pkg::CTRL_HI_ADR, 32'h0003);
		wr(pcrc_pkg::CTRL_LO_ADR, 32'h8000);
		for (int i = 0; i < 17; i++) wr(pcrc_pkg::DATA_ADR, 32'(i));
		rchk(pcrc_pkg::CTRL_LO_ADR, 32'h9080);
		wr(pcrc_pkg::CTRL_LO_ADR, 32'h0);
		rchk(pcrc_pkg::CTRL_LO_ADR, 32'h0040);
		wr(pcrc_pkg::CTRL_HI_ADR, 32'h0007);
		wr(pcrc_pkg::CTRL_LO_ADR, 32'h8000);
		for (int i = 0; i < 9; i++) wr(pcrc_pkg::DATA_ADR, 32'(i));
		rchk(pcrc_pkg::CTRL_LO_ADR, 32'h8880);
		wr(pcrc_pkg::CTRL_LO_ADR, 32'h0);
		$display("test fill done");
	endtask

	// All direction and mode pairs, 8-bit words, polynomial 0x07
	task automatic t_crc;
		logic [31:0] b, e;
		wr(pcrc_pkg::CTRL_HI_ADR, 32'h0707);
		wr(pcrc_pkg::POLY_LO_ADR, 32'h0006);
		wr(pcrc_pkg::IRQ_MASK_ADR, 32'h1);
		for (int k = 0; k < 4; k++) begin
			b = 32'(((k & 1) << 3) | ((k & 2) << 1));
			e = ref_crc(32'h0, 32'h31, 8, 7, b[3], b[2], 32'h06);
			e = ref_crc(e, 32'hc5, 8, 7, b[3], b[2], 32'h06);
			wr(pcrc_pkg::RESULT_ADR, 32'h0);
			wr(pcrc_pkg::CTRL_LO_ADR, 32'h8000 | b);
			wr(pcrc_pkg::DATA_ADR, 32'h31);
			wr(pcrc_pkg::DATA_ADR, 32'hc5);
			wr(pcrc_pkg::CTRL_LO_ADR, 32'h8010 | b);
			poll(pcrc_pkg::IRQ_STAT_ADR, 32'h1, 32'h1);
			chk({31'h0, irq}, 32'h1);
			pcrc_host_inst.xfer(1'b0, pcrc_pkg::RESULT_ADR, 32'h0, q);
			chk(q & 32'hff, e);
			rchk(pcrc_pkg::CTRL_LO_ADR, 32'h8040 | b);
			wr(pcrc_pkg::IRQ_STAT_ADR, 32'h1);
			rchk(pcrc_pkg::IRQ_STAT_ADR, 32'h0);
			chk({31'h0, irq}, 32'h0);
		end
		$display("test crc done");
	endtask

	// Empty-FIFO event while the last word still shifts, masked first;
	// 32-bit polynomial so the high term bits take part
	task automatic t_isel;
		logic [31:0] e;
		e = ref_crc(32'h0, 32'h1234, 16, 31, 1'b0, 1'b0, 32'h04c11db7);
		e = ref_crc(e, 32'h5678, 16, 31, 1'b0, 1'b0, 32'h04c11db7);
		wr(pcrc_pkg::IRQ_MASK_ADR, 32'h0);
		wr(pcrc_pkg::CTRL_HI_ADR, 32'h0f1f);
		wr(pcrc_pkg::POLY_LO_ADR, 32'h1db7);
		wr(pcrc_pkg::POLY_HI_ADR, 32'h04c1);
		wr(pcrc_pkg::RESULT_ADR, 32'h0);
		wr(pcrc_pkg::CTRL_LO_ADR, 32'h8020);
		wr(pcrc_pkg::DATA_ADR, 32'h1234);
		wr(pcrc_pkg::DATA_ADR, 32'h5678);
		wr(pcrc_pkg::CTRL_LO_ADR, 32'h8030);
		poll(pcrc_pkg::IRQ_STAT_ADR, 32'h1, 32'h1);
		rchk(pcrc_pkg::CTRL_LO_ADR, 32'h8070);
		chk({31'h0, irq}, 32'h0);
		wr(pcrc_pkg::IRQ_MASK_ADR, 32'h1);
		chk({31'h0, irq}, 32'h1);
		poll(pcrc_pkg::CTRL_LO_ADR, 32'h0010, 32'h0);
		rchk(pcrc_pkg::RESULT_ADR, e);
		wr(pcrc_pkg::IRQ_STAT_ADR, 32'h1);
		wr(pcrc_pkg::CTRL_LO_ADR, 32'h0);
		$display("test isel done");
	endtask

	// Idle mode freezes the engine only with idle-stop set
	task automatic t_idle;
		wr(pcrc_pkg::CTRL_LO_ADR, 32'ha000);
		@(posedge sys_clk_in) idle_in <= 1'b1;
		wr(pcrc_pkg::DATA_ADR, 32'h00ab);
		wr(pcrc_pkg::CTRL_LO_ADR, 32'ha010);
		repeat (30) @(posedge sys_clk_in);
		rchk(pcrc_pkg::CTRL_LO_ADR, 32'ha110);
		@(posedge sys_clk_in) idle_in <= 1'b0;
		poll(pcrc_pkg::CTRL_LO_ADR, 32'h0010, 32'h0);
		rchk(pcrc_pkg::CTRL_LO_ADR, 32'ha040);
		// Without idle-stop the engine runs on; start clear aborts
		@(posedge sys_clk_in) idle_in <= 1'b1;
		wr(pcrc_pkg::CTRL_LO_ADR, 32'h8000);
		wr(pcrc_pkg::DATA_ADR, 32'h00cd);
		wr(pcrc_pkg::DATA_ADR, 32'h00ef);
		wr(pcrc_pkg::CTRL_LO_ADR, 32'h8010);
		poll(pcrc_pkg::CTRL_LO_ADR, 32'h1f00, 32'h0100);
		wr(pcrc_pkg::CTRL_LO_ADR, 32'h8000);
		rchk(pcrc_pkg::CTRL_LO_ADR, 32'h8100);
		wr(pcrc_pkg::CTRL_LO_ADR, 32'h8010);
		poll(pcrc_pkg::CTRL_LO_ADR, 32'h0010, 32'h0);
		rchk(pcrc_pkg::CTRL_LO_ADR, 32'h8040);
		$display("test idle done");
	endtask

	// Reset, then the scenarios in turn
	initial begin
		rst_n_in = 1'b0;
		idle_in = 1'b0;
		err_count = 0;
		checked = 0;
		repeat (20) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		t_regs();
		t_fill();
		t_crc();
		t_isel();
		t_idle();
		report_and_stop();
	end
endmodule // pcrc_top_bench
